// ===== src/fepc_core.sv
`timescale 1ns/1ps
`default_nettype none
module fepc_core (
  // bit clock domain
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic [4:0] transceiver_station_number,
  // 100 Mb/s transmit code-groups
  input  wire logic [4:0] tx_group,
  input  wire logic       tx_group_valid,
  output logic            tx_group_ready,
  output logic [1:0]      tx_mlt3_level,
  output logic            tx_nrzi,
  // 10 Mb/s transmit nibbles
  input  wire logic [3:0] tx10_nibble,
  input  wire logic       tx10_en,
  output logic            tx10_nibble_ready,
  output logic            tx10_manchester,
  output logic            tx10_active,
  // receive symbols and status
  input  wire logic [1:0] rx_mlt3_level,
  input  wire logic       line_signal_present,
  input  wire logic       link_ok,
  output logic            rx_locked,
  output logic            rx_carrier,
  output logic            rx_clk_from_recovered,
  // MAC side, on the receive clock
  input  wire logic       link_clk,
  input  wire logic       rmii_mode,
  output logic [3:0]      rxd,
  output logic            rx_dv,
  output logic            rx_er,
  output logic [1:0]      rmii_rxd,
  output logic            rmii_crs_dv
);

  typedef struct packed {
    logic                seeded;
    logic [10:0]         tx_lfsr;
    logic [4:0]          tx_sh;
    logic [2:0]          tx_cnt;
    logic                tx_nrzi;
    logic [1:0]          tx_lvl;
    logic                tx_pos;
    logic [3:0]          t10_sh;
    logic [1:0]          t10_bit;
    logic                t10_half;
    logic                t10_act;
    logic                t10_man;
    logic [2:0]          sig_s;
    logic                sig_ok;
    logic [1:0]          rx_prev;
    logic                rx_nrzi;
    logic [10:0]         rx_lfsr;
    logic                rx_lock;
    logic [4:0]          lock_cnt;
    logic [3:0]          idle_run;
    logic [11:0]         win_cnt;
    logic [9:0]          rx_sh;
    logic [2:0]          bit_cnt;
    fepc_pkg::fepc_rx_st_t rx_st;
    logic [3:0]          hold;
    logic                idle_one;
    logic [3:0]          w_nib;
    logic                w_dv;
    logic                w_er;
    logic                w_tog;
  } fepc_core_st_t;

  typedef struct packed {
    logic [2:0] tg_s;
    logic       seen;
    logic [2:0] mode_s;
    logic       mode;
    logic [3:0] rxd;
    logic       dv;
    logic       er;
    logic [1:0] rmii_d;
    logic       rmii_pend;
  } fepc_link_st_t;

  fepc_core_st_t r;
  fepc_core_st_t next_r;
  fepc_link_st_t l;
  fepc_link_st_t next_l;

  logic       tx_key;
  logic       tx_sbit;
  logic       t10_load;
  logic       t10_cur;
  logic       cbit;
  logic       pred;
  logic       dbit;
  logic [9:0] nsh;
  logic [4:0] dec;
  logic       abort;
  logic       new_word;

  // stations differ in seed so parallel ports do not radiate in step
  function automatic logic [10:0] seed_of(input logic [4:0] sn);
    seed_of = {sn, ~sn, 1'b1};
  endfunction

  always_comb
  begin
    next_r = r;
    tx_key = r.tx_lfsr[10] ^ r.tx_lfsr[8];
    tx_sbit = r.tx_sh[4] ^ tx_key;
    tx_group_ready = ce && r.seeded && (r.tx_cnt == fepc_pkg::GRP_LAST);
    t10_cur = r.t10_sh[0];
    t10_load = ce && r.seeded && tx10_en &&
      (!r.t10_act || (r.t10_half && r.t10_bit == fepc_pkg::BIT10_LAST));
    tx10_nibble_ready = t10_load;
    cbit = (rx_mlt3_level != r.rx_prev);
    pred = r.rx_lfsr[10] ^ r.rx_lfsr[8];
    dbit = 1'b1;
    nsh = r.rx_sh;
    dec = 5'h00;
    abort = 1'b0;
    if (ce)
    begin
      if (!r.seeded)
      begin
        // strap is taken on the first enabled edge after reset
        next_r.seeded = 1'b1;
        next_r.tx_lfsr = seed_of(transceiver_station_number);
      end
      else
      begin
        // 100 Mb/s transmit: one bit per enabled edge
        next_r.tx_lfsr = {r.tx_lfsr[9:0], tx_key};
        if (r.tx_cnt == fepc_pkg::GRP_LAST)
        begin
          next_r.tx_cnt = 3'h0;
          next_r.tx_sh = tx_group_valid ? tx_group : fepc_pkg::CG_I;
        end
        else
        begin
          next_r.tx_cnt = r.tx_cnt + 3'h1;
          next_r.tx_sh = {r.tx_sh[3:0], 1'b0};
        end
        if (tx_sbit)
        begin
          next_r.tx_nrzi = ~r.tx_nrzi;
          if (r.tx_lvl != fepc_pkg::LVL_ZERO)
            next_r.tx_lvl = fepc_pkg::LVL_ZERO;
          else
          begin
            next_r.tx_lvl = r.tx_pos ? fepc_pkg::LVL_NEG
                                     : fepc_pkg::LVL_POS;
            next_r.tx_pos = ~r.tx_pos;
          end
        end
        // 10 Mb/s: each enabled edge is one Manchester half bit
        if (r.t10_act)
        begin
          next_r.t10_man = r.t10_half ? t10_cur : ~t10_cur;
          next_r.t10_half = ~r.t10_half;
          if (r.t10_half)
          begin
            next_r.t10_sh = {1'b0, r.t10_sh[3:1]};
            next_r.t10_bit = r.t10_bit + 2'h1;
          end
        end
        else
          next_r.t10_man = 1'b0;
        if (t10_load)
        begin
          next_r.t10_sh = tx10_nibble;
          next_r.t10_bit = 2'h0;
          next_r.t10_half = 1'b0;
          next_r.t10_act = 1'b1;
        end
        else if (r.t10_act && r.t10_half &&
                 r.t10_bit == fepc_pkg::BIT10_LAST)
          next_r.t10_act = 1'b0;
      end

      // signal present passes three stages before it counts
      next_r.sig_s = {r.sig_s[1:0], line_signal_present};
      if (r.sig_s[1] == r.sig_s[2])
        next_r.sig_ok = r.sig_s[2];

      next_r.rx_prev = rx_mlt3_level;
      next_r.rx_nrzi = r.rx_nrzi ^ cbit;

      if (!r.rx_lock)
      begin
        // on idle the plain bits are all ones, so the key is ~bit
        next_r.rx_lfsr = {r.rx_lfsr[9:0], ~cbit};
        next_r.win_cnt = 12'h000;
        if (pred == ~cbit)
        begin
          if (r.lock_cnt == fepc_pkg::LOCK_LAST)
            next_r.rx_lock = 1'b1;
          else
            next_r.lock_cnt = r.lock_cnt + 5'h01;
        end
        else
          next_r.lock_cnt = 5'h00;
      end
      else
      begin
        next_r.rx_lfsr = {r.rx_lfsr[9:0], pred};
        dbit = cbit ^ pred;
        if (r.idle_run == fepc_pkg::IDLE_RUN)
          next_r.win_cnt = 12'h000;
        else if (r.win_cnt == fepc_pkg::WIN_LAST)
        begin
          // no idle in the window: drop lock and search again
          next_r.rx_lock = 1'b0;
          next_r.lock_cnt = 5'h00;
          abort = 1'b1;
        end
        else
          next_r.win_cnt = r.win_cnt + 12'h001;
      end
      if (!r.sig_ok)
      begin
        next_r.rx_lock = 1'b0;
        next_r.lock_cnt = 5'h00;
      end

      if (!dbit)
        next_r.idle_run = 4'h0;
      else if (r.idle_run != fepc_pkg::IDLE_RUN)
        next_r.idle_run = r.idle_run + 4'h1;

      nsh = {r.rx_sh[8:0], dbit};
      next_r.rx_sh = nsh;
      dec = fepc_pkg::fepc_dec(nsh[4:0]);

      case (r.rx_st)
        fepc_pkg::RX_IDLE:
        begin
          next_r.bit_cnt = (r.bit_cnt == fepc_pkg::GRP_LAST) ? 3'h0
                           : r.bit_cnt + 3'h1;
          // clear a stale error or valid word once per group time
          if (r.bit_cnt == fepc_pkg::GRP_LAST && (r.w_er || r.w_dv))
          begin
            next_r.w_dv = 1'b0;
            next_r.w_er = 1'b0;
            next_r.w_tog = ~r.w_tog;
          end
          if (r.rx_lock && !dbit && r.rx_sh[1:0] == 2'h3)
          begin
            next_r.rx_st = fepc_pkg::RX_SSD;
            next_r.bit_cnt = 3'h0;
          end
        end
        fepc_pkg::RX_SSD:
        begin
          next_r.bit_cnt = r.bit_cnt + 3'h1;
          if (r.bit_cnt == fepc_pkg::SSD_LAST)
          begin
            next_r.bit_cnt = 3'h0;
            next_r.w_tog = ~r.w_tog;
            if (nsh == {fepc_pkg::CG_J, fepc_pkg::CG_K})
            begin
              next_r.rx_st = fepc_pkg::RX_FRAME;
              next_r.w_nib = fepc_pkg::NIB_PRE;
              next_r.hold = fepc_pkg::NIB_PRE;
              next_r.w_dv = 1'b1;
              next_r.w_er = 1'b0;
              next_r.idle_one = 1'b0;
            end
            else
            begin
              next_r.rx_st = fepc_pkg::RX_IDLE;
              next_r.w_nib = fepc_pkg::NIB_BAD_SSD;
              next_r.w_dv = 1'b0;
              next_r.w_er = 1'b1;
            end
          end
        end
        fepc_pkg::RX_FRAME:
        begin
          next_r.bit_cnt = r.bit_cnt + 3'h1;
          if (r.bit_cnt == fepc_pkg::GRP_LAST)
          begin
            // output runs one group behind to make room for 0101 0101
            next_r.bit_cnt = 3'h0;
            next_r.w_tog = ~r.w_tog;
            next_r.w_nib = r.hold;
            next_r.w_dv = 1'b1;
            next_r.w_er = 1'b0;
            if (dec[4])
            begin
              next_r.hold = dec[3:0];
              next_r.w_er = r.idle_one;
              next_r.idle_one = 1'b0;
            end
            else if (nsh[4:0] == fepc_pkg::CG_T)
              next_r.rx_st = fepc_pkg::RX_TEND;
            else if (nsh[4:0] == fepc_pkg::CG_I)
            begin
              next_r.idle_one = 1'b1;
              if (r.idle_one)
              begin
                next_r.w_dv = 1'b0;
                next_r.rx_st = fepc_pkg::RX_IDLE;
              end
            end
            else
              next_r.w_er = 1'b1;
          end
        end
        fepc_pkg::RX_TEND:
        begin
          next_r.bit_cnt = r.bit_cnt + 3'h1;
          if (r.bit_cnt == fepc_pkg::GRP_LAST)
          begin
            next_r.bit_cnt = 3'h0;
            next_r.w_tog = ~r.w_tog;
            if (nsh[4:0] == fepc_pkg::CG_R)
            begin
              next_r.w_dv = 1'b0;
              next_r.w_er = 1'b0;
              next_r.rx_st = fepc_pkg::RX_IDLE;
            end
            else
            begin
              next_r.w_dv = 1'b1;
              next_r.w_er = 1'b1;
              next_r.rx_st = fepc_pkg::RX_FRAME;
            end
          end
        end
        default:
          next_r.rx_st = fepc_pkg::RX_IDLE;
      endcase

      // link failure, lost signal or lost lock end the frame at once
      if ((abort || !link_ok || !r.sig_ok) &&
          r.rx_st != fepc_pkg::RX_IDLE)
      begin
        next_r.rx_st = fepc_pkg::RX_IDLE;
        next_r.bit_cnt = 3'h0;
        next_r.w_dv = 1'b0;
        next_r.w_er = 1'b0;
        next_r.w_tog = ~r.w_tog;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r <= '0;
      r.tx_lfsr <= fepc_pkg::LFSR_RST;
      r.tx_sh <= fepc_pkg::CG_I;
      r.rx_lfsr <= fepc_pkg::LFSR_RST;
      r.rx_st <= fepc_pkg::RX_IDLE;
    end
    else
      r <= next_r;
  end

  // MAC side: words cross by toggle; data is stable for a group time
  always_comb
  begin
    next_l = l;
    next_l.tg_s = {l.tg_s[1:0], r.w_tog};
    next_l.mode_s = {l.mode_s[1:0], rmii_mode};
    if (l.mode_s[1] == l.mode_s[2])
      next_l.mode = l.mode_s[2];
    new_word = (l.tg_s[1] == l.tg_s[2]) && (l.tg_s[2] != l.seen);
    if (new_word)
    begin
      next_l.seen = l.tg_s[2];
      next_l.rxd = r.w_nib;
      next_l.dv = r.w_dv;
      next_l.er = r.w_er;
      next_l.rmii_d = r.w_nib[1:0];
      next_l.rmii_pend = l.mode;
    end
    else if (l.rmii_pend)
    begin
      next_l.rmii_d = l.rxd[3:2];
      next_l.rmii_pend = 1'b0;
    end
  end

  // outputs change on the falling edge so the MAC samples mid-bit
  always_ff @(negedge link_clk or negedge nrst)
  begin
    if (!nrst)
      l <= '0;
    else
      l <= next_l;
  end

  assign tx_mlt3_level = r.tx_lvl;
  assign tx_nrzi = r.tx_nrzi;
  assign tx10_manchester = r.t10_man;
  assign tx10_active = r.t10_act;
  assign rx_locked = r.rx_lock;
  assign rx_carrier = (r.rx_st == fepc_pkg::RX_FRAME) ||
                      (r.rx_st == fepc_pkg::RX_TEND);
  // selects the recovered clock while a signal is present
  assign rx_clk_from_recovered = r.sig_ok;
  assign rxd = l.mode ? 4'h0 : l.rxd;
  assign rx_dv = l.mode ? 1'b0 : l.dv;
  assign rx_er = l.er;
  assign rmii_rxd = l.mode ? l.rmii_d : 2'h0;
  assign rmii_crs_dv = l.mode ? l.dv : 1'b0;

endmodule // fepc_core
`default_nettype wire

// ===== src/fepc_pkg.sv
// Function
// - transmit scrambler seed comes from the transceiver station number
// - scrambler shifts each 5-bit code-group out as a serial bit stream
// - scrambled bits become a serial NRZI stream, then MLT-3 for the line
// - MLT-3 one bit changes the output level, zero bit holds it
// - transmit logic runs from the 100 MHz bit clock locked to reference
// - received MLT-3 levels are turned back into an NRZI bit stream
// - descrambler undoes scrambling and reassembles serial bits into groups
// - key synchronises during idle, then is held to descramble data
// - no idle within 40 us window aborts reception and restarts sync
// - /J/K/ fixes code-group boundaries until the next frame start
// - groups map to nibbles; /J/K/ is delivered as 0101 0101
// - start delimiter raises receive data valid
// - /T/R/ or two idles drop carrier and valid, not passed as data
// - valid holds until end delimiter, link failure or signal loss; two idles or lost lock also drop it
// - valid rises with the first translated start delimiter nibble
// - in frame, any group besides data or /T/R/ raises receive error; /I/ itself raises none
// - bad start delimiter gives receive error with 1110, valid stays low
// - MII nibbles change on falling receive clock, MAC samples rising
// - receive clock from recovered data, else from reference clock
// - RMII dibits change on falling reference clock, MAC samples rising
// - 10 Mb/s nibbles are serialised and Manchester encoded
// - invalid group during valid gives error; J K T R I code values
package fepc_pkg;

  localparam int CLK_NS = 10;
  localparam int WIN_NS = 40000;
  // longest time, so the division rounds down
  localparam int WIN_CYC = WIN_NS / CLK_NS;
  localparam logic [11:0] WIN_LAST = 12'(WIN_CYC - 1);

  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_I = 5'h1F;
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [3:0] NIB_BAD_SSD = 4'hE;

  localparam logic [10:0] LFSR_RST = 11'h001;
  localparam logic [4:0] LOCK_LAST = 5'h1D;
  localparam logic [3:0] IDLE_RUN = 4'hA;
  localparam logic [2:0] GRP_LAST = 3'h4;
  localparam logic [2:0] SSD_LAST = 3'h6;
  localparam logic [1:0] BIT10_LAST = 2'h3;

  localparam logic [1:0] LVL_ZERO = 2'h0;
  localparam logic [1:0] LVL_POS = 2'h1;
  localparam logic [1:0] LVL_NEG = 2'h3;

  typedef enum logic [1:0]
  {
    RX_IDLE  = 2'h0,
    RX_SSD   = 2'h1,
    RX_FRAME = 2'h3,
    RX_TEND  = 2'h2
  } fepc_rx_st_t;

  // {valid, nibble} for one code-group
  function automatic logic [4:0] fepc_dec(input logic [4:0] cg);
    case (cg)
      5'h1E: fepc_dec = 5'h10;
      5'h09: fepc_dec = 5'h11;
      5'h14: fepc_dec = 5'h12;
      5'h15: fepc_dec = 5'h13;
      5'h0A: fepc_dec = 5'h14;
      5'h0B: fepc_dec = 5'h15;
      5'h0E: fepc_dec = 5'h16;
      5'h0F: fepc_dec = 5'h17;
      5'h12: fepc_dec = 5'h18;
      5'h13: fepc_dec = 5'h19;
      5'h16: fepc_dec = 5'h1A;
      5'h17: fepc_dec = 5'h1B;
      5'h1A: fepc_dec = 5'h1C;
      5'h1B: fepc_dec = 5'h1D;
      5'h1C: fepc_dec = 5'h1E;
      5'h1D: fepc_dec = 5'h1F;
      default: fepc_dec = 5'h00;
    endcase
  endfunction

endpackage

// ===== testbench/fepc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fepc_checker (
  // bit clock side
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       ce,
  input wire logic       link_ok,
  input wire logic       line_signal_present,
  input wire logic       tx_group_ready,
  input wire logic [1:0] tx_mlt3_level,
  input wire logic       tx_nrzi,
  input wire logic       tx10_nibble_ready,
  input wire logic       tx10_active,
  input wire logic       rx_carrier,
  input wire logic       rx_clk_from_recovered,
  // link side
  input wire logic       link_clk,
  input wire logic       rmii_mode,
  input wire logic [3:0] rxd,
  input wire logic       rx_dv,
  input wire logic       rx_er
);
  logic [2:0] ng;
  logic [2:0] nm;
  logic       seen;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      ng <= 3'h0;
      nm <= 3'h0;
      seen <= 1'b0;
    end
    else if (ce)
    begin
      ng <= tx_group_ready ? 3'h0 : ng + 3'h1;
      nm <= tx10_nibble_ready ? 3'h0 : nm + 3'h1;
      seen <= seen | tx_group_ready;
    end
  tx_spacing_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ce && tx_group_ready && seen |-> ng == 3'h4)
    else $error("group taken off its five bit slot");
  mlt_nrzi_a: assert property (
    @(posedge clk) disable iff (!nrst)
    $changed(tx_nrzi) == $changed(tx_mlt3_level))
    else $error("line level and nrzi disagree");
  mlt_step_a: assert property (
    @(posedge clk) disable iff (!nrst)
    $changed(tx_mlt3_level) && $past(tx_mlt3_level) != fepc_pkg::LVL_ZERO
    |-> tx_mlt3_level == fepc_pkg::LVL_ZERO)
    else $error("line level skipped zero");
  ce_freeze_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !ce |=> $stable(tx_nrzi) && $stable(tx_mlt3_level) && $stable(tx10_active))
    else $error("state moved without enable");
  man_spacing_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ce && tx10_nibble_ready && tx10_active |-> nm == 3'h7)
    else $error("nibble taken off its eight half bit slot");
  link_fail_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ce && !link_ok |=> !rx_carrier)
    else $error("carrier kept over link failure");
  sig_loss_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !line_signal_present |-> ##[0:600] !rx_clk_from_recovered && !rx_carrier)
    else $error("signal loss not followed");
  bad_ssd_a: assert property (
    @(posedge link_clk) disable iff (!nrst)
    !rmii_mode && !$past(rmii_mode, 4) && rx_er && !rx_dv
    |-> rxd == fepc_pkg::NIB_BAD_SSD)
    else $error("bad start delimiter nibble wrong");
  dv_preamble_a: assert property (
    @(posedge link_clk) disable iff (!nrst)
    $rose(rx_dv) |-> rxd == fepc_pkg::NIB_PRE && !rx_er)
    else $error("valid rose without preamble nibble");
  cover property (@(posedge link_clk) disable iff (!nrst) $rose(rx_dv));
  cover property (@(posedge link_clk) disable iff (!nrst) rx_er && !rx_dv);
  cover property (@(posedge link_clk) disable iff (!nrst) rx_er && rx_dv);
  cover property (@(posedge clk) disable iff (!nrst)
    tx10_nibble_ready && tx10_active);
endmodule // fepc_checker
bind fepc_core fepc_checker u_chk (
  .clk(clk), .nrst(nrst), .ce(ce), .link_ok(link_ok),
  .line_signal_present(line_signal_present),
  .tx_group_ready(tx_group_ready), .tx_mlt3_level(tx_mlt3_level),
  .tx_nrzi(tx_nrzi), .tx10_nibble_ready(tx10_nibble_ready),
  .tx10_active(tx10_active), .rx_carrier(rx_carrier),
  .rx_clk_from_recovered(rx_clk_from_recovered), .link_clk(link_clk),
  .rmii_mode(rmii_mode), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er));
`default_nettype wire

// ===== testbench/fepc_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module fepc_mac_model #(
  parameter int HOLD = 10
) (
  // receive lines
  input  wire logic       link_clk,
  input  wire logic [3:0] rxd,
  input  wire logic       rx_dv,
  input  wire logic       rx_er,
  // one pulse per word seen
  output logic            word_stb,
  output logic [5:0]      word
);
  // equal neighbours are told apart by their fixed stand time only
  logic [5:0] last = 6'h00;
  int         cnt = 0;
  always @(posedge link_clk)
  begin
    word_stb <= 1'b0;
    if ({rx_dv, rx_er, rxd} !== last || cnt == HOLD)
    begin
      cnt = 1;
      word_stb <= rx_dv | rx_er;
      word <= {rx_dv, rx_er, rxd};
    end
    else
      cnt = cnt + 1;
    last = {rx_dv, rx_er, rxd};
  end
endmodule // fepc_mac_model
`default_nettype wire

// ===== testbench/test_fast_ethernet_pcs_coding_path.sv
`timescale 1ns/1ps
`default_nettype none
module test_fast_ethernet_pcs_coding_path;
  // slowed bit rate so a group lasts exactly ten link periods
  localparam int CE_DIV = 25;
  localparam int LIMIT = 60000;
  localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A,
    5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B,
    5'h1C, 5'h1D};
  logic       clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       nrst = 1'b0;
  logic       ce = 1'b0;
  logic [4:0] sn = 5'h00;
  logic [4:0] grp = 5'h1F;
  logic       grp_v = 1'b0;
  logic [3:0] nib = 4'h0;
  logic       nib_en = 1'b0;
  logic       sig = 1'b1;
  logic       link_ok = 1'b1;
  logic       ign = 1'b0;
  logic       man_due = 1'b0;
  logic       grp_rdy, nrzi, nib_rdy, man, act, locked, carrier, rclk;
  logic       rx_dv, rx_er, word_stb, rmii_crs_dv;
  logic [1:0] mlt3, rmii_rxd;
  logic [3:0] rxd;
  logic [5:0] word;
  logic [6:0] e;
  logic [6:0] exp_q[$];
  logic       man_q[$];
  int         n_mismatch = 0;
  int         total_checks = 0;
  int         cyc = 0;
  int         div = 0;
  int         seed = 32'h5707a2ab;
  fepc_core DUT (
    .clk(clk), .nrst(nrst), .ce(ce), .transceiver_station_number(sn),
    .tx_group(grp), .tx_group_valid(grp_v), .tx_group_ready(grp_rdy),
    .tx_mlt3_level(mlt3), .tx_nrzi(nrzi), .tx10_nibble(nib),
    .tx10_en(nib_en), .tx10_nibble_ready(nib_rdy),
    .tx10_manchester(man), .tx10_active(act),
    .rx_mlt3_level(mlt3),
    .line_signal_present(sig), .link_ok(link_ok), .rx_locked(locked),
    .rx_carrier(carrier), .rx_clk_from_recovered(rclk),
    .link_clk(link_clk), .rmii_mode(1'b0), .rxd(rxd), .rx_dv(rx_dv),
    .rx_er(rx_er), .rmii_rxd(rmii_rxd), .rmii_crs_dv(rmii_crs_dv));
  fepc_mac_model #(.HOLD(CE_DIV * 50 / 125)) mac (
    .link_clk(link_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er),
    .word_stb(word_stb), .word(word));
  always #5 clk = ~clk;
  initial
  begin
    #3.3;
    forever #62.5 link_clk = ~link_clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    div <= (div == CE_DIV - 1) ? 0 : div + 1;
    ce <= #1 (div == CE_DIV - 1);
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic x, input logic g);
    total_checks++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("[FAIL] %s: expected %b seen %b", nm, x, g);
    end
  endtask
  task automatic send(input logic [4:0] g, input logic v);
    grp = g;
    grp_v = v;
    do @(posedge clk); while (grp_rdy !== 1'b1);
    #1;
  endtask
  task automatic tx10(input logic [3:0] n);
    nib = n;
    nib_en = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      man_q.push_back(~n[i]);
      man_q.push_back(n[i]);
    end
    do @(posedge clk); while (nib_rdy !== 1'b1);
    #1;
  endtask
  // a negative bad index gives a clean frame
  task automatic frame(input int n, input int bad, input logic tr);
    logic [3:0] d;
    exp_q.push_back({3'b110, fepc_pkg::NIB_PRE});
    exp_q.push_back({3'b110, fepc_pkg::NIB_PRE});
    send(fepc_pkg::CG_J, 1'b1);
    send(fepc_pkg::CG_K, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      d = 4'($random(seed));
      // output lags a group: the error rides on the word before the bad
      // group, and the word after it repeats held data without error
      if (i == bad)
      begin
        void'(exp_q.pop_back());
        exp_q.push_back(7'h30);
        exp_q.push_back(7'h20);
      end
      else
        exp_q.push_back({3'b110, d});
      send(i == bad ? 5'h00 : ENC[d], 1'b1);
    end
    send(tr ? fepc_pkg::CG_T : fepc_pkg::CG_I, 1'b1);
    send(tr ? fepc_pkg::CG_R : fepc_pkg::CG_I, 1'b1);
    repeat (6) send(fepc_pkg::CG_I, 1'b1);
  endtask
  // rxd is a don't care where the top bit of a note is clear
  always @(posedge link_clk)
    if (word_stb === 1'b1 && !ign)
    begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 7'h00;
      total_checks++;
      if (word[5:4] !== e[5:4] || (e[6] && word[3:0] !== e[3:0]))
      begin
        n_mismatch++;
        $display("[FAIL] mii word: expected %h seen %h", e[5:0], word);
      end
    end
  // an enabled edge while busy launches one half bit; look once it settled
  always @(posedge clk)
    man_due <= ce && (act === 1'b1);
  always @(negedge clk)
    if (man_due)
    begin
      total_checks++;
      if (man_q.size() == 0 || man !== man_q[0])
      begin
        n_mismatch++;
        $display("[FAIL] manchester: expected %b seen %b",
                 (man_q.size() == 0) ? 1'bx : man_q[0], man);
      end
      if (man_q.size() != 0)
        void'(man_q.pop_front());
    end
  initial
  begin
    sn = 5'($random(seed));
    repeat (4) @(posedge clk);
    @(negedge link_clk);
    @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) tx10(4'($random(seed)));
    nib_en = 1'b0;
    repeat (30) send(fepc_pkg::CG_I, 1'b0);
    chk("lock", 1'b1, locked);
    chk("manchester drained", 1'b1, man_q.size() == 0);
    exp_q.push_back(7'h5E);
    send(fepc_pkg::CG_J, 1'b1);
    repeat (8) send(fepc_pkg::CG_I, 1'b1);
    frame(12, -1, 1'b1);
    frame(6, 2, 1'b1);
    frame(5, -1, 1'b0);
    chk("words drained", 1'b1, exp_q.size() == 0);
    ign = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      repeat (30) send(fepc_pkg::CG_I, 1'b1);
      send(fepc_pkg::CG_J, 1'b1);
      send(fepc_pkg::CG_K, 1'b1);
      repeat (3) send(ENC[k], 1'b1);
      chk("carrier in frame", 1'b1, carrier);
      sig = (k != 0);
      link_ok = (k == 0);
      repeat (4) send(fepc_pkg::CG_I, 1'b1);
      chk("valid after abort", 1'b0, rx_dv);
      chk("carrier after abort", 1'b0, carrier);
      chk("recovered clock", k == 1, rclk);
      sig = 1'b1;
      link_ok = 1'b1;
    end
    final_report();
  end
endmodule // test_fast_ethernet_pcs_coding_path
`default_nettype wire
